// *** hdl/cfg_port_pkg.sv ***
// Constants shared by the serial configuration port and its output serialiser.
package cfg_port_pkg;

    // Serial word layout: address first, then data, most significant bit first.
    localparam int unsigned WORD_BITS = 24;
    localparam int unsigned ADDR_BITS = 8;
    localparam int unsigned DATA_BITS = 16;
    localparam int unsigned CNT_W     = 5;
    localparam logic [4:0]  LAST_BIT  = 5'h17;
    localparam int unsigned ADDR_MSB  = 23;
    localparam int unsigned ADDR_LSB  = 16;

    // Power register address and the position of its power-down field.
    localparam logic [7:0]  PWR_REG_ADDR = 8'h0F;
    localparam int unsigned PWR_PD_BIT   = 9;

    // Sample output: four channels, two lanes each, four bits per lane per frame.
    localparam int unsigned CHANNELS      = 4;
    localparam int unsigned LANES         = 8;
    localparam int unsigned SAMPLE_BITS   = 8;
    localparam int unsigned BITS_PER_LANE = 4;
    localparam logic [1:0]  PHASE_LAST    = 2'h3;
    localparam logic [1:0]  PHASE_HALF    = 2'h2;

    // Reset values of the pins seen through the synchroniser.
    localparam logic [4:0]  PIN_RST_VAL = 5'h0A;
    localparam int unsigned PIN_SCLK    = 0;
    localparam int unsigned PIN_SEL_N   = 1;
    localparam int unsigned PIN_SERIAL_IN_LINE   = 2;
    localparam int unsigned PIN_PRST_N  = 3;
    localparam int unsigned PIN_PD      = 4;

    // Word assembly states, Gray coded along idle, shift, ignore.
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SHIFT  = 2'b01,
        ST_IGNORE = 2'b11
    } word_state_t;

endpackage

// *** hdl/pin_sync.sv ***
// Two-stage synchroniser for a group of pins from outside the MCLK domain.
`timescale 1ns/100ps
module pin_sync #(
    parameter int unsigned W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock, reset and enable.
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // Raw pins and synchronised copies.
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // First stage; read only by the second stage.
    logic [W-1:0] meta_r;

    // Both stages advance together; the reset value keeps pins idle.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else if (ce) begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

// *** hdl/cfg_serial_port.sv ***
// Serial configuration port with word assembly, power control and lane serialiser.
`timescale 1ns/100ps
// Overview of operation
// - Shift bits only while select is low.
// - Sample data on each rising serial clock.
// - Every 24th rising edge writes the word.
// - Each 24-bit group is its own write.
// - Optionally ignore bits beyond first 24.
// - First eight bits are register address.
// - Next sixteen bits are register data.
// - Capture uses edges only, not duty cycle.
// - Port reset pin resets serial logic.
// - Drive bit clock, frame clock, eight lanes.
module cfg_serial_port (
    // Clock, reset and enable.
    input  wire logic        MCLK,
    input  wire logic        RESET_N,
    input  wire logic        CE,
    // Serial configuration pins from the host.
    input  wire logic        SCLK,
    input  wire logic        PORT_SELECT_N,
    input  wire logic        SERIAL_IN_LINE,
    input  wire logic        PORT_RESET_N,
    input  wire logic        POWERDOWN_INPUT,
    // Same-domain strap choosing single-word transfers.
    input  wire logic        ONE_WORD_MODE,
    // Register write port towards the configuration registers.
    output logic             WR_STROBE,
    output logic [7:0]       WR_ADDR,
    output logic [15:0]      WR_DATA,
    // Status.
    output logic             BUSY,
    output logic             INIT_DONE,
    // Sample input and serial sample outputs, positive legs.
    input  wire logic [31:0] SAMPLE_IN,
    output logic             BIT_CLOCK_OUT_P,
    output logic             FRAME_CLOCK_OUT_P,
    output logic [7:0]       LANE_OUT_P
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation.

    // Synchronised copies of all asynchronous pins.
    logic [4:0] pins_s;

    pin_sync #(
        .W       (5),
        .RST_VAL (cfg_port_pkg::PIN_RST_VAL)
    ) u_pin_sync (
        .clk   (MCLK),
        .rst_n (RESET_N),
        .ce    (CE),
        .d     ({POWERDOWN_INPUT, PORT_RESET_N, SERIAL_IN_LINE, PORT_SELECT_N, SCLK}),
        .q     (pins_s)
    );

    // Named views of the synchronised pins.
    wire sclk_s   = pins_s[cfg_port_pkg::PIN_SCLK];
    wire sel_n_s  = pins_s[cfg_port_pkg::PIN_SEL_N];
    wire serial_in_line_s  = pins_s[cfg_port_pkg::PIN_SERIAL_IN_LINE];
    wire prst_n_s = pins_s[cfg_port_pkg::PIN_PRST_N];
    wire pd_s     = pins_s[cfg_port_pkg::PIN_PD];

    ////////////////////////////////////////////////////////////////////////////
    // Serial clock edge detection.

    // Previous synchronised serial clock and power-down levels.
    logic sclk_prev_r;
    logic pd_prev_r;

    // Only the rising transition counts, so any high/low ratio works.
    wire sclk_rise = sclk_s & ~sclk_prev_r;
    wire pd_fall   = pd_prev_r & ~pd_s;
    // Serial logic is held in reset by either reset source.
    wire port_rst  = ~RESET_N | ~prst_n_s;

    // Edge history; cleared by chip reset only so no edge is invented.
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            sclk_prev_r <= 1'b0;
            pd_prev_r   <= 1'b0;
        end else if (CE) begin
            sclk_prev_r <= sclk_s;
            pd_prev_r   <= pd_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word assembly.

    cfg_port_pkg::word_state_t state_r, state_nxt;

    // Shift register and bit counter of the word under assembly.
    logic [23:0] shift_r;
    logic [23:0] shift_nxt;
    logic [4:0]  cnt_r;
    logic [4:0]  cnt_nxt;

    // New bit enters at the bottom: first bit ends at the top.
    wire [23:0] shift_in  = {shift_r[22:0], serial_in_line_s};
    wire        selected  = ~sel_n_s;
    wire        take_bit  = selected & sclk_rise;
    wire        word_done = take_bit & (cnt_r == cfg_port_pkg::LAST_BIT);
    // Write strobe fires only from the shift state.
    wire        write_go  = word_done & (state_r == cfg_port_pkg::ST_SHIFT);

    // Next-state logic of the word assembler.
    always_comb begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        cnt_nxt   = cnt_r;
        unique case (state_r)
            // Wait for select; a fresh word always starts at bit zero.
            cfg_port_pkg::ST_IDLE: begin
                cnt_nxt = '0;
                if (selected) begin
                    state_nxt = cfg_port_pkg::ST_SHIFT;
                    if (sclk_rise) begin
                        shift_nxt = shift_in;
                        cnt_nxt   = 5'h01;
                    end
                end
            end
            // Collect bits; deselect drops whatever is partial.
            cfg_port_pkg::ST_SHIFT: begin
                if (!selected) begin
                    state_nxt = cfg_port_pkg::ST_IDLE;
                    cnt_nxt   = '0;
                end else if (word_done) begin
                    shift_nxt = shift_in;
                    cnt_nxt   = '0;
                    if (ONE_WORD_MODE) begin
                        state_nxt = cfg_port_pkg::ST_IGNORE;
                    end
                end else if (take_bit) begin
                    shift_nxt = shift_in;
                    cnt_nxt   = cnt_r + 5'h01;
                end
            end
            // Excess bits are dropped until select rises.
            cfg_port_pkg::ST_IGNORE: begin
                cnt_nxt = '0;
                if (!selected) begin
                    state_nxt = cfg_port_pkg::ST_IDLE;
                end
            end
            // Unused code recovers to idle.
            default: begin
                state_nxt = cfg_port_pkg::ST_IDLE;
                cnt_nxt   = '0;
            end
        endcase
    end

    // Assembler registers, cleared by either reset source.
    always_ff @(posedge MCLK) begin
        if (port_rst) begin
            state_r <= cfg_port_pkg::ST_IDLE;
            shift_r <= '0;
            cnt_r   <= '0;
        end else if (CE) begin
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register write port.

    // Top eight bits address the register, low sixteen carry the value.
    wire [7:0]  word_addr = shift_in[cfg_port_pkg::ADDR_MSB:cfg_port_pkg::ADDR_LSB];
    wire [15:0] word_data = shift_in[15:0];

    // Strobe lasts one cycle; address and data hold until the next write or either reset source.
    always_ff @(posedge MCLK) begin
        if (port_rst) begin
            WR_STROBE <= 1'b0;
            WR_ADDR   <= '0;
            WR_DATA   <= '0;
        end else if (CE) begin
            WR_STROBE <= write_go;
            if (write_go) begin
                WR_ADDR <= word_addr;
                WR_DATA <= word_data;
            end
        end
    end

    // Busy while a word is partly received.
    assign BUSY = (state_r == cfg_port_pkg::ST_SHIFT) & (cnt_r != '0);

    ////////////////////////////////////////////////////////////////////////////
    // Power control.

    // Serial power-down field, set and cleared by writes to the power register.
    logic spi_pd_r;
    logic init_r;

    wire pwr_write = write_go & (word_addr == cfg_port_pkg::PWR_REG_ADDR);
    // Sample outputs stay quiet while either power-down source is active; the write port keeps working.
    wire powered_dn = pd_s | spi_pd_r;

    // Initialisation is done once the pin pulse ends or power-down is written.
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            spi_pd_r <= 1'b0;
            init_r   <= 1'b0;
        end else if (CE) begin
            if (pwr_write) begin
                spi_pd_r <= word_data[cfg_port_pkg::PWR_PD_BIT];
            end
            if (pd_fall | (pwr_write & word_data[cfg_port_pkg::PWR_PD_BIT])) begin
                init_r <= 1'b1;
            end
        end
    end

    assign INIT_DONE = init_r;

    ////////////////////////////////////////////////////////////////////////////
    // Sample serialiser.

    // Frame phase, bit clock and lane shift registers.
    logic [1:0]      phase_r;
    logic            bclk_r;
    logic            fclk_r;
    logic [7:0][3:0] lane_r;
    logic [7:0][3:0] lane_load;

    // Lane A takes a channel's upper nibble, lane B its lower nibble.
    for (genvar ch = 0; ch < cfg_port_pkg::CHANNELS; ch++) begin : g_lane
        assign lane_load[2*ch]   = SAMPLE_IN[ch*8+7 -: 4];
        assign lane_load[2*ch+1] = SAMPLE_IN[ch*8+3 -: 4];
    end

    wire       frame_start = (phase_r == cfg_port_pkg::PHASE_LAST);
    wire [1:0] phase_nxt   = phase_r + 2'h1;

    // One bit per MCLK, i.e. per bit clock edge; a frame is one 8-bit sample.
    always_ff @(posedge MCLK) begin
        if (!RESET_N || powered_dn) begin
            phase_r <= cfg_port_pkg::PHASE_LAST;
            bclk_r  <= 1'b0;
            fclk_r  <= 1'b0;
            lane_r  <= '0;
        end else if (CE) begin
            phase_r <= phase_nxt;
            bclk_r  <= ~bclk_r;
            fclk_r  <= (phase_nxt < cfg_port_pkg::PHASE_HALF);
            if (frame_start) begin
                lane_r <= lane_load;
            end else begin
                for (int l = 0; l < cfg_port_pkg::LANES; l++) begin
                    lane_r[l] <= {lane_r[l][2:0], 1'b0};
                end
            end
        end
    end

    // Each lane sends its most significant bit first.
    for (genvar l = 0; l < cfg_port_pkg::LANES; l++) begin : g_out
        assign LANE_OUT_P[l] = lane_r[l][3];
    end

    assign BIT_CLOCK_OUT_P   = bclk_r;
    assign FRAME_CLOCK_OUT_P = fclk_r;

endmodule

// *** sim/cfg_port_asserts.sv ***
// Concurrent checks on the top ports of the serial configuration port.
`timescale 1ns/100ps
module cfg_port_asserts (
    // Clock and reset.
    input wire logic        MCLK,
    input wire logic        RESET_N,
    // Link pins.
    input wire logic        SCLK,
    input wire logic        PORT_SELECT_N,
    input wire logic        PORT_RESET_N,
    // Outputs under watch.
    input wire logic        WR_STROBE,
    input wire logic [7:0]  WR_ADDR,
    input wire logic [15:0] WR_DATA,
    input wire logic        INIT_DONE,
    input wire logic        BIT_CLOCK_OUT_P,
    input wire logic        FRAME_CLOCK_OUT_P
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    ////////////////////////////////////////////////////////////////////////////
    // A write only follows a serial clock rise that the pins held high.
    sel_quiet_a: assert property (PORT_SELECT_N [*8] |-> !WR_STROBE)
        else $error("write strobe while deselected");
    strobe_sclk_a: assert property (WR_STROBE |-> $past(SCLK, 2) && $past(SCLK, 3))
        else $error("write strobe without a serial clock rise");
    strobe_gap_a: assert property (WR_STROBE |=> !WR_STROBE [*8])
        else $error("write strobes too close");
    addr_hold_a: assert property ($changed(WR_ADDR) && !WR_STROBE |-> WR_ADDR == 8'h00)
        else $error("write address moved without a write");
    // The pin passes two sync stages before clearing the write port.
    port_reset_a: assert property (!PORT_RESET_N [*4] |-> !WR_STROBE && WR_DATA == 16'h0000)
        else $error("port reset left write data");
    init_sticky_a: assert property (INIT_DONE |=> INIT_DONE)
        else $error("init flag dropped");
    bit_clock_a: assert property (BIT_CLOCK_OUT_P |=> !BIT_CLOCK_OUT_P)
        else $error("bit clock high twice");
    frame_low_a: assert property ($rose(FRAME_CLOCK_OUT_P) |-> !$past(FRAME_CLOCK_OUT_P, 2))
        else $error("frame clock low too short");
endmodule
bind cfg_serial_port cfg_port_asserts chk (.MCLK, .RESET_N, .SCLK, .PORT_SELECT_N,
    .PORT_RESET_N, .WR_STROBE, .WR_ADDR, .WR_DATA, .INIT_DONE, .BIT_CLOCK_OUT_P,
    .FRAME_CLOCK_OUT_P);

// *** sim/serial_host.sv ***
// Behavioural host that drives the three-wire configuration link.
`timescale 1ns/100ps
module serial_host (
    // Clock the host steps on.
    input  wire logic clk,
    // Link pins towards the port.
    output logic      sclk,
    output logic      sel_n,
    output logic      serial_in_line
);
    initial begin
        sclk  = 1'b0;
        sel_n = 1'b1;
        serial_in_line = 1'b0;
    end
    // A released data line must not keep a stale bit, so it toggles.
    always @(posedge clk) begin
        if (sel_n) begin
            serial_in_line <= ~serial_in_line;
        end
    end
    // Select falls well ahead of the first rise.
    task automatic open();
        sel_n <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // Sends the top n bits of w, first bit first, hi cycles high per bit.
    task automatic xfer(input logic [23:0] w, input int n, input int hi);
        for (int i = 23; i > 23 - n; i--) begin
            serial_in_line <= w[i];
            repeat (8 - hi) @(posedge clk);
            sclk <= 1'b1;
            repeat (hi) @(posedge clk);
            sclk <= 1'b0;
        end
    endtask
    // Ends the frame; the serial clock then stands still.
    task automatic close();
        sel_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule

// *** sim/adc_config_serial_port_tb.sv ***
// Self-checking bench for the serial configuration port.
`timescale 1ns/100ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fails++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module adc_config_serial_port_tb;
    logic        mclk = 1'b0;
    logic        reset_n = 1'b0;
    logic        prst_n = 1'b1;
    logic        pd = 1'b0;
    logic        one_word = 1'b0;
    wire  logic  sclk, sel_n, serial_in_line, wr_strobe, busy, init_done, bclk, fclk;
    wire  logic [7:0]  wr_addr, lanes;
    wire  logic [15:0] wr_data;
    int          fails = 0, n_tests = 0, strobes = 0, cycles = 0, s0;
    logic        q;
    always #20 mclk = ~mclk;
    serial_host host (.clk(mclk), .sclk(sclk), .sel_n(sel_n), .serial_in_line(serial_in_line));
    cfg_serial_port DUT (.MCLK(mclk), .RESET_N(reset_n), .CE(1'b1), .SCLK(sclk),
        .PORT_SELECT_N(sel_n), .SERIAL_IN_LINE(serial_in_line), .PORT_RESET_N(prst_n),
        .POWERDOWN_INPUT(pd), .ONE_WORD_MODE(one_word), .WR_STROBE(wr_strobe),
        .WR_ADDR(wr_addr), .WR_DATA(wr_data), .BUSY(busy), .INIT_DONE(init_done),
        .SAMPLE_IN(32'hA5C3_0FF0), .BIT_CLOCK_OUT_P(bclk), .FRAME_CLOCK_OUT_P(fclk),
        .LANE_OUT_P(lanes));
    // Counts write strobes and cuts a hang short.
    always @(posedge mclk) begin
        cycles++;
        if (wr_strobe === 1'b1) strobes++;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic send_word(input logic [23:0] w);
        host.open();
        host.xfer(w, 24, 4);
        host.close();
    endtask
    // Samples the bit clock for four cycles and compares its activity.
    task automatic bclk_active(input logic exp);
        q = 1'b0;
        repeat (4) begin
            @(posedge mclk);
            q = q | bclk;
        end
        `CHK(q, exp)
    endtask
    task automatic t_power();
        `CHK(init_done, 1'b0)
        pd <= 1'b1;
        repeat (6) @(posedge mclk);
        pd <= 1'b0;
        repeat (6) @(posedge mclk);
        `CHK(init_done, 1'b1)
        send_word(24'h0F_0200);
        bclk_active(1'b0);
        send_word(24'h0F_0000);
        bclk_active(1'b1);
        $display("power test done");
    endtask
    task automatic t_single();
        s0 = strobes;
        send_word(24'h3A_C5A1);
        `CHK(strobes - s0, 1)
        `CHK(wr_addr, 8'h3A)
        `CHK(wr_data, 16'hC5A1)
        $display("single word test done");
    endtask
    // Two words in one frame with skewed serial clock duty cycles.
    task automatic t_two_words(input logic mode);
        // Let an edge pass so the strap is never assigned twice in one step.
        @(posedge mclk);
        one_word <= mode;
        s0 = strobes;
        host.open();
        host.xfer(24'h44_0001, 24, 3);
        host.xfer(24'h21_FEDC, 24, 5);
        host.close();
        `CHK(strobes - s0, mode ? 1 : 2)
        `CHK(wr_addr, mode ? 8'h44 : 8'h21)
        `CHK(wr_data, mode ? 16'h0001 : 16'hFEDC)
        one_word <= 1'b0;
        $display("two word test done");
    endtask
    task automatic t_partial();
        s0 = strobes;
        host.open();
        host.xfer(24'h77_7777, 12, 4);
        `CHK(busy, 1'b1)
        host.close();
        `CHK(busy, 1'b0)
        `CHK(strobes - s0, 0)
        send_word(24'h09_0A0B);
        `CHK(wr_addr, 8'h09)
        `CHK(wr_data, 16'h0A0B)
        $display("partial word test done");
    endtask
    task automatic t_port_reset();
        prst_n <= 1'b0;
        repeat (6) @(posedge mclk);
        prst_n <= 1'b1;
        `CHK(wr_addr, 8'h00)
        `CHK(wr_data, 16'h0000)
        $display("port reset test done");
    endtask
    // Waits for a frame clock rise, then follows one frame of all eight lanes.
    task automatic t_lanes();
        q = 1'b1;
        repeat (8) begin
            @(posedge mclk);
            if (q === 1'b0 && fclk === 1'b1) break;
            q = fclk;
        end
        `CHK({q, fclk}, 2'b01)
        `CHK(lanes, 8'h59)
        @(posedge mclk);
        `CHK({fclk, lanes}, 9'h199)
        @(posedge mclk);
        `CHK({fclk, lanes}, 9'h069)
        @(posedge mclk);
        `CHK({fclk, lanes}, 9'h0A9)
        $display("lane test done");
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_power();
        t_single();
        t_two_words(1'b0);
        t_two_words(1'b1);
        t_partial();
        t_port_reset();
        t_lanes();
        complete_run();
    end
endmodule
